/* File: tb/xna_access_unit_tb.sv */
`timescale 1ns/1ns
module xna_access_unit_tb;
    import xna_pkg::*;
    logic        clk_i       = 1'b0;
    logic        rst_n_i     = 1'b0;
    logic        req_wr_i    = 1'b0;
    logic        req_rd_i    = 1'b0;
    logic [7:0]  req_addr_i  = 8'h00;
    logic [7:0]  req_wdata_i = 8'h00;
    logic [3:0]  lock_field_i = 4'h0;
    logic        abort_en    = 1'b0;
    logic [7:0]  nvm_delay   = 8'h0A;
    logic [3:0]  sel;
    logic        rsp_valid_o;
    logic [15:0] rsp_rdata_o;
    logic        nvm_req;
    logic        nvm_we;
    logic [5:0]  nvm_addr;
    logic [31:0] nvm_wdata;
    logic [1:0]  nvm_margin;
    logic        nvm_done;
    logic        nvm_abort;
    logic [31:0] nvm_rdata;
    logic        unlocked_o;
    logic        access_fault_flag_o;
    logic [7:0]  n_req;
    logic [1:0]  margin;
    logic [15:0] g;
    int          n_fail      = 0;
    int          compares    = 0;
    int          i;

    always #2 clk_i = ~clk_i;

    xna_access_unit #(.WR_TMO_CYC(50)) dut (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .req_wr_i(req_wr_i),
        .req_rd_i(req_rd_i), .req_addr_i(req_addr_i),
        .req_wdata_i(req_wdata_i), .rsp_valid_o(rsp_valid_o),
        .rsp_rdata_o(rsp_rdata_o), .lock_field_i(lock_field_i),
        .nvm_req_o(nvm_req), .nvm_we_o(nvm_we), .nvm_addr_o(nvm_addr),
        .nvm_wdata_o(nvm_wdata), .nvm_margin_o(nvm_margin),
        .nvm_done_i(nvm_done), .nvm_abort_i(nvm_abort),
        .nvm_rdata_i(nvm_rdata), .unlocked_o(unlocked_o),
        .access_fault_flag_o(access_fault_flag_o));

    xna_nvm_model nvm (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .nvm_req_i(nvm_req),
        .nvm_we_i(nvm_we), .nvm_addr_i(nvm_addr), .nvm_wdata_i(nvm_wdata),
        .nvm_margin_i(nvm_margin), .nvm_done_o(nvm_done),
        .nvm_abort_o(nvm_abort), .nvm_rdata_o(nvm_rdata),
        .delay_i(nvm_delay), .abort_en_i(abort_en), .n_req_o(n_req),
        .margin_o(margin));

    ////////////////////////////////////////////////////////////////////
    task automatic test_done;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] s);
        compares++;
        if (s !== e) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        #1;
        req_addr_i  = a;
        req_wdata_i = d;
        req_wr_i    = 1'b1;
        @(posedge clk_i);
        #1;
        req_wr_i = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk_i);
        #1;
        req_addr_i = a;
        req_rd_i   = 1'b1;
        @(posedge clk_i);
        #1;
        req_rd_i = 1'b0;
        chk("rsp_valid", 32'h1, {31'h0, rsp_valid_o});
        d = rsp_rdata_o;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [15:0] e,
                        input string nm);
        logic [15:0] s;
        rd(a, s);
        chk(nm, {16'h0, e}, {16'h0, s});
    endtask

    // Bounded poll of a done byte
    task automatic wait_done(input logic [7:0] a);
        logic [15:0] s;
        int k;
        s = 16'h0000;
        for (k = 0; k < 200 && s[0] !== 1'b1; k++) rd(a, s);
        chk("done flag", 32'h1, {31'h0, s[0]});
    endtask

    task automatic ext_wr(input logic [7:0] a, input logic [31:0] w);
        wr(ADR_WR_ADDR, a);
        wr(ADR_WR_DATA0, w[31:24]);
        wr(ADR_WR_DATA1, w[23:16]);
        wr(ADR_WR_DATA2, w[15:8]);
        wr(ADR_WR_DATA3, w[7:0]);
        wr(ADR_WR_CTRL, 8'h80);
    endtask

    task automatic ext_rd(input logic [7:0] a);
        wr(ADR_RD_ADDR, a);
        wr(ADR_RD_CTRL, 8'h80);
    endtask

    task automatic clr_fault;
        wr(ADR_CTRL, 8'h02);
        rchk(ADR_WARN, 16'hB000, "fault clear");
    endtask

    ////////////////////////////////////////////////////////////////////
    // Tests need a few hundred cycles; this allows over a hundred times more
    initial begin
        #200000;
        n_fail++;
        test_done();
    end

    initial begin
        repeat (5) @(posedge clk_i);
        #1;
        rst_n_i = 1'b1;
        rchk(ADR_WARN, 16'hB000, "warn reset");
        chk("unlocked reset", 32'h0, {31'h0, unlocked_o});
        rchk(8'h12, 16'h0000, "unused reg");
        // Shadow traffic without any key
        ext_wr(8'h45, 32'h12345678);
        rchk(ADR_WR_CTRL, 16'h0001, "shadow wr done");
        rchk(ADR_WR_ADDR, 16'h0045, "wr addr");
        rchk(ADR_WR_DATA0, 16'h1234, "wr data hi");
        ext_rd(8'h45);
        rchk(8'h0D, 16'h0001, "shadow rd done");
        rchk(ADR_RD_ADDR, 16'h0045, "rd addr");
        rchk(ADR_RD_HI, 16'h0034, "shadow hi");
        rchk(ADR_RD_LO, 16'h5678, "shadow lo");
        // Auxiliary space reads as zero at once
        ext_rd(8'h90);
        rchk(8'h0D, 16'h0001, "aux rd done");
        rchk(ADR_RD_LO, 16'h0000, "aux lo");
        // EEPROM write while still locked
        ext_wr(8'h1F, 32'h58A45678);
        rchk(ADR_WR_CTRL, 16'h0001, "refused done");
        rchk(ADR_WARN, 16'hB080, "refused fault");
        chk("fault pin", 32'h1, {31'h0, access_fault_flag_o});
        chk("nvm requests", 32'h0, {24'h0, n_req});
        clr_fault();
        chk("fault pin off", 32'h0, {31'h0, access_fault_flag_o});
        // Broken key, then a tail without its first byte
        wr(ADR_KEY, 8'h00);
        wr(ADR_KEY, 8'h27);
        wr(ADR_KEY, 8'h55);
        for (i = 1; i < 5; i++) wr(ADR_KEY, KEY_SEQ[i]);
        rchk(ADR_WARN, 16'hB000, "warn");
        chk("partial key", 32'h0, {31'h0, unlocked_o});
        for (i = 0; i < 5; i++) wr(ADR_KEY, KEY_SEQ[i]);
        rchk(ADR_WARN, 16'hB000, "warn");
        chk("full key", 32'h1, {31'h0, unlocked_o});
        // Bits 25:24 set on purpose; they must read back as zero
        ext_wr(8'h1F, 32'h5BA45678);
        rchk(ADR_WR_CTRL, 16'h0100, "ee wr busy");
        wait_done(8'h09);
        chk("ee word", 32'h5BA45678, nvm.mem[6'h1F]);
        rchk(ADR_WARN, 16'hB000, "ee wr fault");
        // Reads at each threshold select code, margins first
        for (i = 0; i < 3; i++) begin
            sel = 4'(i == 2 ? 0 : i + 1);
            wr(ADR_CTRL, {sel, 4'h0});
            ext_rd(8'h1F);
            rchk(ADR_RD_CTRL, 16'h0100, "ee rd busy");
            wait_done(8'h0D);
            rchk(ADR_RD_HI, 16'h58A4, "ee hi");
            rchk(ADR_RD_LO, 16'h5678, "ee lo");
            chk("margin", {28'h0, sel}, {30'h0, margin});
            rd(ADR_CTRL, g);
            chk("select", {28'h0, sel}, {28'h0, g[15:12]});
        end
        // Aborted EEPROM write
        abort_en = 1'b1;
        ext_wr(8'h20, 32'h00000001);
        wait_done(8'h09);
        rchk(ADR_WARN, 16'hB080, "abort fault");
        abort_en = 1'b0;
        clr_fault();
        // Write that outlasts the write timeout
        nvm_delay = 8'hFF;
        ext_wr(8'h21, 32'h00000002);
        rchk(ADR_WR_CTRL, 16'h0100, "slow wr busy");
        wait_done(8'h09);
        rchk(ADR_WARN, 16'hB080, "timeout fault");
        nvm_delay = 8'h0A;
        clr_fault();
        // Stored protect codes
        lock_field_i = LOCK_EE;
        ext_wr(8'h1F, 32'h00000000);
        rchk(ADR_WR_CTRL, 16'h0001, "lock ee done");
        rchk(ADR_WARN, 16'hB080, "lock ee fault");
        clr_fault();
        ext_wr(8'h45, 32'h00ABCDEF);
        rchk(ADR_WARN, 16'hB000, "lock ee shadow");
        lock_field_i = LOCK_ALL;
        ext_wr(8'h45, 32'h00111111);
        rchk(ADR_WARN, 16'hB080, "lock all shadow");
        ext_rd(8'h45);
        rchk(8'h0D, 16'h0001, "lock all rd done");
        rchk(ADR_RD_HI, 16'h00AB, "lock all hi");
        rchk(ADR_RD_LO, 16'hCDEF, "lock all lo");
        chk("nvm requests", 32'h6, {24'h0, n_req});
        test_done();
    end
endmodule

/* File: tb/xna_nvm_model.sv */
`timescale 1ns/1ns
module xna_nvm_model (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // Macro port: requests driven by the unit, done, abort and data driven back to it
    input  wire logic        nvm_req_i,
    input  wire logic        nvm_we_i,
    input  wire logic [5:0]  nvm_addr_i,
    input  wire logic [31:0] nvm_wdata_i,
    input  wire logic [1:0]  nvm_margin_i,
    output logic             nvm_done_o,
    output logic             nvm_abort_o,
    output logic      [31:0] nvm_rdata_o,
    // Bench controls and observations
    input  wire logic [7:0]  delay_i,
    input  wire logic        abort_en_i,
    output logic      [7:0]  n_req_o,
    output logic      [1:0]  margin_o
);
    logic [31:0] mem [64];
    logic [7:0]  cnt_q;
    logic        busy_q;

    always_ff @(posedge clk_i) begin
        nvm_done_o  <= 1'b0;
        nvm_abort_o <= 1'b0;
        // Junk outside the done cycle, so stale data cannot pass
        nvm_rdata_o <= ~nvm_rdata_o;
        if (!rst_n_i) begin
            busy_q      <= 1'b0;
            cnt_q       <= 8'h00;
            n_req_o     <= 8'h00;
            margin_o    <= 2'h0;
            nvm_rdata_o <= 32'h0000_0000;
        end else if (!busy_q) begin
            if (nvm_req_i) begin
                busy_q   <= 1'b1;
                cnt_q    <= delay_i;
                n_req_o  <= n_req_o + 8'h01;
                margin_o <= nvm_margin_i;
            end
        end else if (nvm_done_o || nvm_abort_o) begin
            busy_q <= 1'b0;
        end else if (cnt_q != 8'h00) begin
            cnt_q <= cnt_q - 8'h01;
        end else if (nvm_we_i && abort_en_i) begin
            nvm_abort_o <= 1'b1;
        end else begin
            nvm_done_o <= 1'b1;
            if (nvm_we_i) begin
                mem[nvm_addr_i] <= nvm_wdata_i;
            end else begin
                nvm_rdata_o <= mem[nvm_addr_i];
            end
        end
    end
endmodule

/* File: verilog/xna_access_unit.sv */
`timescale 1ns/1ns
module xna_access_unit
    import xna_pkg::*;
#(
    parameter int unsigned WR_TMO_CYC = WR_MAX_CYC
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // Direct register byte port
    input  wire logic        req_wr_i,
    input  wire logic        req_rd_i,
    input  wire logic [7:0]  req_addr_i,
    input  wire logic [7:0]  req_wdata_i,
    output logic             rsp_valid_o,
    output logic      [15:0] rsp_rdata_o,
    // Stored write-protect field
    input  wire logic [3:0]  lock_field_i,
    // EEPROM macro port
    output logic             nvm_req_o,
    output logic             nvm_we_o,
    output logic      [5:0]  nvm_addr_o,
    output logic      [31:0] nvm_wdata_o,
    output logic      [1:0]  nvm_margin_o,
    input  wire logic        nvm_done_i,
    input  wire logic        nvm_abort_i,
    input  wire logic [31:0] nvm_rdata_i,
    // Status
    output logic             unlocked_o,
    output logic             access_fault_flag_o
);

    xna_state_type st_q;
    logic [7:0]       write_target_address_q;
    logic [31:0]      write_data_word_q;
    logic [7:0]       read_target_address_q;
    logic [31:0]      read_data_word_q;
    logic             read_done_flag_q;
    logic             write_done_flag_q;
    logic             access_fault_flag_q;
    logic [3:0]       special_q;
    logic [2:0]       key_step_q;
    logic             unlocked_q;
    logic [TMO_W-1:0] tmo_q;
    logic [23:0]      shadow_mem [64];

    ////////////////////////////////////////////////////////////////////////
    // Decode

    wire wr_at_key  = req_wr_i && req_addr_i == ADR_KEY;
    wire key_match  = req_wdata_i == KEY_SEQ[key_step_q];
    wire key_first  = req_wdata_i == KEY_SEQ[0];
    wire rd_launch  = req_wr_i && req_addr_i == ADR_RD_CTRL
                      && req_wdata_i[LAUNCH_BIT];
    wire wr_launch  = req_wr_i && req_addr_i == ADR_WR_CTRL
                      && req_wdata_i[LAUNCH_BIT];
    // A launch while busy is dropped; done stays clear meanwhile
    wire rd_go      = st_q == ST_IDLE && rd_launch;
    wire wr_go      = st_q == ST_IDLE && wr_launch;
    wire rd_ee      = read_target_address_q[7:6] == REG_EE;
    wire rd_sh      = read_target_address_q[7:6] == REG_SH;
    wire wr_ee      = write_target_address_q[7:6] == REG_EE;
    wire wr_sh      = write_target_address_q[7:6] == REG_SH;
    wire lock_all   = lock_field_i == LOCK_ALL;
    wire lock_ee    = lock_field_i == LOCK_EE || lock_all;
    wire wr_viol    = (wr_ee && (!unlocked_q || lock_ee))
                      || (wr_sh && lock_all);
    wire tmo_zero   = tmo_q == '0;
    wire rd_end     = st_q == ST_RD && (nvm_done_i || tmo_zero);
    wire rd_fail    = st_q == ST_RD && !nvm_done_i && tmo_zero;
    wire wr_fail    = st_q == ST_WR
                      && (nvm_abort_i || (!nvm_done_i && tmo_zero));
    wire wr_end     = st_q == ST_WR && (nvm_done_i || wr_fail);
    wire fault_set  = (wr_go && wr_viol) || wr_fail || rd_fail;
    wire fault_clr  = req_wr_i && req_addr_i == ADR_CTRL
                      && req_wdata_i[CLW_BIT];
    wire [1:0] mrg_sel = special_q == SPC_LOW  ? MRG_LOW  :
                         special_q == SPC_HIGH ? MRG_HIGH :
                         MRG_NONE;
    wire [31:0] ee_word = {nvm_rdata_i[31:26], 2'b00,
                           nvm_rdata_i[23:0]};
    // Shadow cells hold no ECC; upper byte reads as zero
    wire [31:0] sh_word = {8'h00,
                           shadow_mem[read_target_address_q[5:0]]};
    // Auxiliary space is outside this unit and reads as zero
    wire [31:0] fast_word = rd_sh ? sh_word : 32'h0000_0000;

    // Word-wide read view, aligned to the even byte address
    wire [7:0]  even_addr = {req_addr_i[7:1], 1'b0};
    wire [15:0] rd_view =
        even_addr == (ADR_WR_ADDR & 8'hFE) ?
            {8'h00, write_target_address_q} :
        even_addr == ADR_WR_DATA0 ? write_data_word_q[31:16] :
        even_addr == ADR_WR_DATA2 ? write_data_word_q[15:0] :
        even_addr == ADR_WR_CTRL  ?
            {7'h00, st_q == ST_WR, 7'h00, write_done_flag_q} :
        even_addr == (ADR_RD_ADDR & 8'hFE) ?
            {8'h00, read_target_address_q} :
        even_addr == ADR_RD_CTRL  ?
            {7'h00, st_q == ST_RD, 7'h00, read_done_flag_q} :
        even_addr == ADR_RD_HI    ? read_data_word_q[31:16] :
        even_addr == ADR_RD_LO    ? read_data_word_q[15:0] :
        even_addr == ADR_CTRL     ? {special_q, 12'h000} :
        even_addr == ADR_WARN     ?
            {WARN_TAG, 4'h0, access_fault_flag_q, 7'h00} :
        16'h0000;
    // Odd address returns only its own byte
    wire [15:0] rd_byte_sel = req_addr_i[0] ? {8'h00, rd_view[7:0]}
                                            : rd_view;

    ////////////////////////////////////////////////////////////////////////
    // Register port: read answered next cycle, any request every cycle

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rsp_valid_o <= 1'b0;
            rsp_rdata_o <= 16'h0000;
        end else begin
            rsp_valid_o <= req_rd_i;
            if (req_rd_i) begin
                rsp_rdata_o <= rd_byte_sel;
            end
        end
    end

    // Plain direct registers, written at any time
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            write_target_address_q <= 8'h00;
            write_data_word_q      <= 32'h0000_0000;
            read_target_address_q  <= 8'h00;
            special_q              <= 4'h0;
        end else if (req_wr_i) begin
            unique case (req_addr_i)
                ADR_WR_ADDR:  write_target_address_q <= req_wdata_i;
                ADR_WR_DATA0: write_data_word_q[31:24] <= req_wdata_i;
                ADR_WR_DATA1: write_data_word_q[23:16] <= req_wdata_i;
                ADR_WR_DATA2: write_data_word_q[15:8]  <= req_wdata_i;
                ADR_WR_DATA3: write_data_word_q[7:0]   <= req_wdata_i;
                ADR_RD_ADDR:  read_target_address_q <= req_wdata_i;
                ADR_CTRL:     special_q <= req_wdata_i[SPECIAL_LSB +: 4];
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Unlock sequence

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            key_step_q <= 3'h0;
            unlocked_q <= 1'b0;
        end else if (wr_at_key && !unlocked_q) begin
            if (key_match && key_step_q == KEY_LAST) begin
                unlocked_q <= 1'b1;
            end else if (key_match) begin
                key_step_q <= key_step_q + 3'h1;
            end else begin
                // A stray byte restarts, but may itself begin a sequence
                key_step_q <= key_first ? 3'h1 : 3'h0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Shadow memory, reloaded elsewhere at power-up

    always_ff @(posedge clk_i) begin
        if (wr_go && wr_sh && !wr_viol) begin
            shadow_mem[write_target_address_q[5:0]] <=
                write_data_word_q[23:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Transaction engine

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            st_q              <= ST_IDLE;
            read_data_word_q  <= 32'h0000_0000;
            read_done_flag_q  <= 1'b0;
            write_done_flag_q <= 1'b0;
            nvm_req_o         <= 1'b0;
            nvm_we_o          <= 1'b0;
            nvm_addr_o        <= 6'h00;
            nvm_wdata_o       <= 32'h0000_0000;
            nvm_margin_o      <= MRG_NONE;
            tmo_q             <= '0;
        end else begin
            unique case (st_q)
                ST_IDLE: begin
                    if (rd_go && rd_ee) begin
                        read_done_flag_q <= 1'b0;
                        nvm_req_o    <= 1'b1;
                        nvm_we_o     <= 1'b0;
                        nvm_addr_o   <= read_target_address_q[5:0];
                        nvm_margin_o <= mrg_sel;
                        tmo_q        <= TMO_W'(RD_MAX_CYC);
                        st_q         <= ST_RD;
                    end else if (rd_go) begin
                        read_data_word_q <= fast_word;
                        read_done_flag_q <= 1'b1;
                    end else if (wr_go && wr_ee && !wr_viol) begin
                        write_done_flag_q <= 1'b0;
                        nvm_req_o   <= 1'b1;
                        nvm_we_o    <= 1'b1;
                        nvm_addr_o  <= write_target_address_q[5:0];
                        nvm_wdata_o <= write_data_word_q;
                        tmo_q       <= TMO_W'(WR_TMO_CYC);
                        st_q        <= ST_WR;
                    end else if (wr_go) begin
                        // Shadow, aux or refused: ends at once
                        write_done_flag_q <= 1'b1;
                    end
                end
                ST_RD: begin
                    tmo_q <= tmo_q - TMO_W'(1);
                    if (rd_end) begin
                        read_data_word_q <= ee_word;
                        read_done_flag_q <= 1'b1;
                        nvm_req_o        <= 1'b0;
                        nvm_margin_o     <= MRG_NONE;
                        st_q             <= ST_IDLE;
                    end
                end
                ST_WR: begin
                    tmo_q <= tmo_q - TMO_W'(1);
                    if (wr_end) begin
                        write_done_flag_q <= 1'b1;
                        nvm_req_o         <= 1'b0;
                        nvm_we_o          <= 1'b0;
                        st_q              <= ST_IDLE;
                    end
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    // Fault flag: a new event wins over a clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            access_fault_flag_q <= 1'b0;
        end else begin
            access_fault_flag_q <= fault_set
                || (access_fault_flag_q && !fault_clr);
        end
    end

    assign unlocked_o          = unlocked_q;
    assign access_fault_flag_o = access_fault_flag_q;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    a_unlock_only_seq: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $rose(unlocked_q) |-> $past(wr_at_key && key_step_q == KEY_LAST
            && req_wdata_i == KEY_SEQ[4]))
        else $error("unlock without final key byte");

    a_unlock_sticky: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        unlocked_q |=> unlocked_q)
        else $error("unlock lost before reset");

    a_ee_write_lock: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        wr_go && wr_ee && lock_field_i == LOCK_EE
            |=> !nvm_req_o && write_done_flag_q && access_fault_flag_q)
        else $error("locked EEPROM write not refused");

    a_shadow_lock: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        wr_go && wr_sh && lock_all |=> access_fault_flag_q
            && write_done_flag_q && st_q == ST_IDLE)
        else $error("shadow write under full lock not refused");

    a_fast_read_done: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        rd_go && !rd_ee |=> read_done_flag_q && st_q == ST_IDLE)
        else $error("shadow read not done in one cycle");

    a_ee_read_bound: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        rd_go && rd_ee |=> !read_done_flag_q ##[1:501] read_done_flag_q)
        else $error("EEPROM read exceeded its time");

    a_read_format: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $rose(read_done_flag_q) |-> read_data_word_q[25:24] == 2'b00)
        else $error("read word bits 25:24 not zero");

    a_margin_code: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        rd_go && rd_ee && special_q == SPC_LOW
            |=> nvm_margin_o == MRG_LOW && nvm_req_o)
        else $error("low threshold not applied");

    a_margin_high: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        rd_go && rd_ee && special_q == SPC_HIGH
            |=> nvm_margin_o == MRG_HIGH && nvm_req_o)
        else $error("high threshold not applied");

    a_pipe_answer: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        req_rd_i && req_addr_i == ADR_RD_ADDR
            |=> rsp_valid_o && rsp_rdata_o == {8'h00, read_target_address_q})
        else $error("read answer missing or wrong");

endmodule

/* File: verilog/xna_pkg.sv */
package xna_pkg;

    // Direct serial register byte addresses
    localparam logic [7:0] ADR_WR_ADDR  = 8'h03;
    localparam logic [7:0] ADR_WR_DATA0 = 8'h04;
    localparam logic [7:0] ADR_WR_DATA1 = 8'h05;
    localparam logic [7:0] ADR_WR_DATA2 = 8'h06;
    localparam logic [7:0] ADR_WR_DATA3 = 8'h07;
    localparam logic [7:0] ADR_WR_CTRL  = 8'h08;
    localparam logic [7:0] ADR_RD_ADDR  = 8'h0B;
    localparam logic [7:0] ADR_RD_CTRL  = 8'h0C;
    localparam logic [7:0] ADR_RD_HI    = 8'h0E;
    localparam logic [7:0] ADR_RD_LO    = 8'h10;
    localparam logic [7:0] ADR_CTRL     = 8'h1E;
    localparam logic [7:0] ADR_WARN     = 8'h26;
    localparam logic [7:0] ADR_KEY      = 8'h3C;

    // Field positions
    localparam int LAUNCH_BIT  = 7;
    localparam int CLW_BIT     = 1;
    localparam int SPECIAL_LSB = 4;

    // Fixed upper nibble of the warning register
    localparam logic [3:0] WARN_TAG = 4'hB;

    // Unlock byte sequence, entry 0 written first
    localparam logic [4:0][7:0] KEY_SEQ =
        {8'h77, 8'h1F, 8'h81, 8'h27, 8'h00};
    localparam logic [2:0] KEY_LAST = 3'h4;

    // Stored write-protect codes
    localparam logic [3:0] LOCK_EE  = 4'hC;
    localparam logic [3:0] LOCK_ALL = 4'h3;

    // Threshold select codes and margin strobes
    localparam logic [3:0] SPC_LOW   = 4'h1;
    localparam logic [3:0] SPC_HIGH  = 4'h2;
    localparam logic [1:0] MRG_NONE  = 2'h0;
    localparam logic [1:0] MRG_LOW   = 2'h1;
    localparam logic [1:0] MRG_HIGH  = 2'h2;

    // Extended address regions (bits 7:6)
    localparam logic [1:0] REG_EE = 2'h0;
    localparam logic [1:0] REG_SH = 2'h1;

    // Timing
    localparam int unsigned CLK_PERIOD_NS = 4;
    localparam int unsigned CLK_MHZ       = 250;
    localparam int unsigned RD_TIME_NS    = 2000;
    localparam int unsigned WR_TIME_MS    = 24;
    localparam int unsigned RD_MAX_CYC    = RD_TIME_NS / CLK_PERIOD_NS;
    localparam int unsigned WR_MAX_CYC    = WR_TIME_MS * 1000 * CLK_MHZ;
    localparam int          TMO_W         = 23;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RD   = 2'b01,
        ST_WR   = 2'b10
    } xna_state_type;

endpackage
